// *** design/dcmc_top.sv ***
// Downstream charging mode controller for the four hub ports.
`timescale 1ns/1ps
`include "dcmc_defines.svh"

// Behaviour
// R1: One enable bit per downstream port.
// R2: Clear enable bit gives no charging.
// R3: Connected, configured, powered port uses CDP.
// R4: Auto disabled and unconnected uses DCP.
// R5: Unconnected enabled port drives power on.
// R6: Tiers and vendor mode only in auto.
// R7: High tier only with high-current bit.
// R8: Start in top tier, stay without pull-up.
// R9: Tier pull-up: power off, vendor or DCP.
// R10: Vendor pull-up: power off, then DCP.
// R11: DCP pull-up or voltage: back to tiers.
// R12: Cycle repeats until upstream connects.
// R13: Full sweep tries every tier downward.
// R14: Vendor mode only when its disable clear.
// R15: Without sweep, one tier then DCP.
// R16: Sweep without high-current skips top tier.
// R17: Pin configuration uses reset-sampled pins.
// R18: Pin mode sweeps all tiers, OTP vendor.
// R19: Enable pins stable around reset release.
// R20: Charging forces per-port power management.
// R21: Each port has its own machine.
// R22: Upstream connect leaves the auto cycle.
module dcmc_top
    import dcmc_pkg::*;
#(
    parameter int NPORT          = 4,
    parameter int CNT_W          = 16,
    parameter int PWR_OFF_CYCLES = `DCMC_PWR_OFF_CYC
) (
    // Clock and reset.
    input  wire logic              clk_sys,
    input  wire logic              sys_rst,
    // Register access port.
    input  wire logic              reg_wr_en,
    input  wire logic              reg_rd_en,
    input  wire logic [7:0]        reg_addr,
    input  wire logic [7:0]        reg_wdata,
    output logic      [7:0]        reg_rdata_ff,
    // Enable and mode pins sampled at reset release; the OTP vendor bit is read live.
    input  wire logic [NPORT-1:0]  charge_enable_pins,
    input  wire logic              pin_config_mode,
    input  wire logic              vendor_disable_otp,
    // Hub state.
    input  wire logic              upstream_vbus_ok,
    input  wire logic              hub_configured,
    input  wire logic [NPORT-1:0]  host_port_power,
    // Per-port line detection.
    input  wire logic [NPORT-1:0]  dp_pullup_det,
    input  wire logic [NPORT-1:0]  data_line_voltage_detect,
    // Port controls.
    output logic      [NPORT-1:0]  port_power_en_ff,
    output dcmc_state_e            port_mode_ff [NPORT],
    output logic                   full_power_managed_ff
);

    // ------------------------------------------------------------
    // Input synchronisation
    // ------------------------------------------------------------
    localparam int SW = 3 * NPORT + 2;

    logic [SW-1:0]    sync_q;      // Synchronised pin levels.
    logic [NPORT-1:0] pins_s;      // Enable pins.
    logic             pmode_s;     // Pin configuration strap.
    logic             conn;        // Upstream bus voltage present.
    logic [NPORT-1:0] pu_s;        // D+ pull-up seen per port.
    logic [NPORT-1:0] vd_s;        // Data-line voltage per port.

    // Strap, bus-voltage and line pins come from outside the clock domain.
    dcmc_sync2 #(
        .W (SW)
    ) u_sync (
        .clk_sys  (clk_sys),
        .sys_rst  (sys_rst),
        .async_in ({charge_enable_pins, pin_config_mode,
                    upstream_vbus_ok, dp_pullup_det,
                    data_line_voltage_detect}),
        .sync_out (sync_q)
    );

    assign pins_s  = sync_q[SW-1 -: NPORT];
    assign pmode_s = sync_q[2*NPORT+1];
    assign conn    = sync_q[2*NPORT];
    assign pu_s    = sync_q[NPORT +: NPORT];
    assign vd_s    = sync_q[NPORT-1:0];

    // ------------------------------------------------------------
    // Strap capture
    // ------------------------------------------------------------
    logic [1:0]       strap_cnt_ff;  // Waits out the synchroniser.
    logic             strap_done_ff; // Straps are valid.
    logic [NPORT-1:0] pin_en_ff;     // Captured enable pins.
    logic             pin_mode_ff;   // Captured configuration strap.

    // The pins are caught once, after the synchroniser has filled,
    // so the levels held across reset release are the ones used.
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            strap_cnt_ff  <= 2'h0;
            strap_done_ff <= 1'b0;
            pin_en_ff     <= '0;
            pin_mode_ff   <= 1'b0;
        end else if (!strap_done_ff) begin
            strap_cnt_ff <= strap_cnt_ff + 2'h1;
            if (strap_cnt_ff == `DCMC_STRAP_DLY) begin
                strap_done_ff <= 1'b1;
                pin_en_ff     <= pins_s;   // [R17] [R19]
                pin_mode_ff   <= pmode_s;  // [R17]
            end
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [7:0] port_charge_enable;     // Per-port enable bits.
    logic [7:0] charge_mode_config;     // Tier and auto settings.
    logic [7:0] extended_charge_config; // Sweep and vendor.

    // Software writes land on the addressed register only.
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            port_charge_enable     <= `DCMC_PORT_EN_RST;
            charge_mode_config     <= `DCMC_MODE_CFG_RST;
            extended_charge_config <= `DCMC_EXT_CFG_RST;
        end else if (reg_wr_en) begin
            case (reg_addr)
                `DCMC_PORT_EN_OFF:  port_charge_enable     <= reg_wdata;
                `DCMC_MODE_CFG_OFF: charge_mode_config     <= reg_wdata;
                `DCMC_EXT_CFG_OFF:  extended_charge_config <= reg_wdata;
                default: begin
                    // Unmapped writes are ignored.
                end
            endcase
        end
    end

    // Reads answer one cycle later; unmapped offsets read zero.
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            reg_rdata_ff <= 8'h00;
        end else if (reg_rd_en) begin
            case (reg_addr)
                `DCMC_PORT_EN_OFF:  reg_rdata_ff <= port_charge_enable;
                `DCMC_MODE_CFG_OFF: reg_rdata_ff <= charge_mode_config;
                `DCMC_EXT_CFG_OFF:  reg_rdata_ff <= extended_charge_config;
                `DCMC_STATUS_OFF:   reg_rdata_ff <= {3'h0, strap_done_ff,
                                                     port_power_en_ff};
                default:            reg_rdata_ff <= 8'h00;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Effective configuration
    // ------------------------------------------------------------
    logic [NPORT-1:0] en_eff;  // Charging enabled per port.
    logic             auto_on; // Automatic sequencing.
    logic             hc;      // High-current tier allowed.
    logic             full;    // Sweep every tier.
    logic             ven;     // Vendor mode in the cycle.

    // Pin mode ignores the register bits entirely and runs the
    // full sweep with the high tier; nothing charges before the
    // straps are valid.
    assign en_eff  = strap_done_ff ? (pin_mode_ff ? pin_en_ff :
                     port_charge_enable[NPORT-1:0]) : '0;   // [R1] [R17]
    assign auto_on = pin_mode_ff |
                     ~charge_mode_config[`DCMC_AUTODIS_BIT]; // [R4] [R18]
    assign hc      = pin_mode_ff |
                     charge_mode_config[`DCMC_HICUR_BIT];    // [R7] [R18]
    assign full    = pin_mode_ff |
                     extended_charge_config[`DCMC_FULL_BIT]; // [R13] [R18]
    assign ven     = pin_mode_ff ? ~vendor_disable_otp :
                     ~extended_charge_config[`DCMC_VENDDIS_BIT]; // [R14]

    // Charging forces per-port power control.
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            full_power_managed_ff <= 1'b0;
        end else begin
            full_power_managed_ff <= |en_eff;  // [R20]
        end
    end

    // ------------------------------------------------------------
    // Sequence helpers
    // ------------------------------------------------------------
    // First tier of a cycle: high only with the high-current bit.
    function automatic dcmc_state_e top_tier(input logic h);
        return h ? ST_HIGH : ST_MID;  // [R7] [R8] [R15]
    endfunction

    // Mode after a tier that saw a pull-up.
    function automatic dcmc_state_e after_tier(
        input dcmc_state_e t, input logic f, input logic v);
        dcmc_state_e r;
        r = v ? ST_VENDOR : ST_DCP;          // [R9] [R14]
        if (f && t == ST_HIGH) r = ST_MID;   // [R13] [R16]
        if (f && t == ST_MID)  r = ST_LOW;   // [R13]
        return r;
    endfunction

    // ------------------------------------------------------------
    // Per-port machines
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    // One machine per port; no port reads another's state.
    genvar gi;
    generate
        for (gi = 0; gi < NPORT; gi++) begin : g_port  // [R21]
            dcmc_state_e      tgt_ff;    // Mode after power-off.
            dcmc_state_e      nxt_state; // Next mode.
            dcmc_state_e      nxt_tgt;   // Next target.
            logic             nxt_pwr;   // Next power enable.
            logic [CNT_W-1:0] cnt_ff;    // Power-off dwell count.
            logic             dwell_done;

            assign dwell_done =
                (cnt_ff == CNT_W'(PWR_OFF_CYCLES - 1));

            // Mode selection. Connection and enable are checked
            // first, so a connect ends the cycle from any state.
            always_comb begin
                nxt_state = port_mode_ff[gi];
                nxt_tgt   = tgt_ff;
                if (!en_eff[gi]) begin
                    nxt_state = ST_NONE;                 // [R2]
                end else if (conn) begin
                    // Until the host powers the port there is
                    // nothing to advertise.
                    nxt_state = (hub_configured && host_port_power[gi])
                              ? ST_CDP : ST_NONE;        // [R3] [R22]
                end else if (!auto_on) begin
                    nxt_state = ST_DCP;                  // [R4] [R6]
                end else begin
                    case (port_mode_ff[gi])
                        ST_HIGH, ST_MID, ST_LOW: begin
                            if (pu_s[gi]) begin
                                nxt_state = ST_PWROFF;   // [R9]
                                nxt_tgt   = after_tier(port_mode_ff[gi],
                                                       full, ven);
                            end else if (port_mode_ff[gi] == ST_HIGH
                                         && !hc) begin
                                nxt_state = ST_MID;      // [R7]
                            end
                        end
                        ST_VENDOR: begin
                            if (pu_s[gi]) begin
                                nxt_state = ST_PWROFF;   // [R10]
                                nxt_tgt   = ST_DCP;
                            end else if (!ven) begin
                                nxt_state = ST_DCP;      // [R14]
                            end
                        end
                        ST_DCP: begin
                            if (pu_s[gi] || vd_s[gi]) begin
                                nxt_state = ST_PWROFF;   // [R11]
                                nxt_tgt   = top_tier(hc); // [R12]
                            end
                        end
                        ST_PWROFF: begin
                            // The vendor and high-current settings may
                            // change in the dwell; re-check on the way out.
                            if (dwell_done) begin
                                nxt_state = tgt_ff;
                                if (tgt_ff == ST_VENDOR && !ven)
                                    nxt_state = ST_DCP;  // [R14]
                                if (tgt_ff == ST_HIGH && !hc)
                                    nxt_state = ST_MID;  // [R7]
                            end
                        end
                        default: begin
                            nxt_state = top_tier(hc);    // [R8]
                        end
                    endcase
                end
                // Power is held off during the dwell; in NONE and CDP it follows host power.
                case (nxt_state)
                    ST_PWROFF:      nxt_pwr = 1'b0;      // [R9] [R10]
                    ST_NONE, ST_CDP: nxt_pwr = host_port_power[gi];
                    default:        nxt_pwr = 1'b1;      // [R5]
                endcase
            end

            // Mode, target and power move together.
            always_ff @(posedge clk_sys or posedge sys_rst) begin
                if (sys_rst) begin
                    port_mode_ff[gi]     <= ST_NONE;
                    tgt_ff               <= ST_DCP;
                    port_power_en_ff[gi] <= 1'b0;
                end else begin
                    port_mode_ff[gi]     <= nxt_state;
                    tgt_ff               <= nxt_tgt;
                    port_power_en_ff[gi] <= nxt_pwr;
                end
            end

            // Dwell counter runs only while in the power-off mode.
            always_ff @(posedge clk_sys or posedge sys_rst) begin
                if (sys_rst) begin
                    cnt_ff <= '0;
                end else if (port_mode_ff[gi] == ST_PWROFF) begin
                    cnt_ff <= cnt_ff + CNT_W'(1);
                end else begin
                    cnt_ff <= '0;
                end
            end

            // ----------------------------------------------------
            // Checks
            // ----------------------------------------------------
            disabled_no_charge_a: assert property ( // [R2]
                !en_eff[gi] |=> port_mode_ff[gi] == ST_NONE)
                else $error("Disabled port is charging");
            cdp_when_connected_a: assert property ( // [R3]
                en_eff[gi] && conn && hub_configured &&
                host_port_power[gi] |=> port_mode_ff[gi] == ST_CDP)
                else $error("Connected port not in CDP");
            dcp_no_auto_a: assert property ( // [R4]
                en_eff[gi] && !conn && !auto_on
                |=> port_mode_ff[gi] == ST_DCP && port_power_en_ff[gi])
                else $error("Auto disabled port not in DCP");
            power_on_modes_a: assert property ( // [R5]
                port_mode_ff[gi] inside {ST_DCP, ST_HIGH, ST_MID,
                                         ST_LOW, ST_VENDOR}
                |-> port_power_en_ff[gi])
                else $error("Charging mode without port power");
            high_tier_gate_a: assert property ( // [R7]
                port_mode_ff[gi] == ST_HIGH && $past(port_mode_ff[gi])
                != ST_HIGH |-> $past(hc))
                else $error("High tier entered without high current");
            tier_pullup_off_a: assert property ( // [R9]
                en_eff[gi] && !conn && auto_on && pu_s[gi] &&
                port_mode_ff[gi] inside {ST_HIGH, ST_MID, ST_LOW}
                |=> port_mode_ff[gi] == ST_PWROFF && !port_power_en_ff[gi])
                else $error("Tier pull-up did not drop power");
            sweep_order_a: assert property ( // [R13]
                en_eff[gi] && !conn && auto_on && full && pu_s[gi] &&
                port_mode_ff[gi] == ST_HIGH |=> tgt_ff == ST_MID)
                else $error("Sweep did not step to middle tier");
            dcp_return_a: assert property ( // [R11]
                en_eff[gi] && !conn && auto_on && vd_s[gi] &&
                port_mode_ff[gi] == ST_DCP
                |=> port_mode_ff[gi] == ST_PWROFF ##0
                    tgt_ff == ($past(hc) ? ST_HIGH : ST_MID))
                else $error("DCP detection did not restart tiers");
            vendor_gate_a: assert property ( // [R14]
                port_mode_ff[gi] == ST_VENDOR |-> $past(ven))
                else $error("Vendor mode while disabled");
            connect_leaves_a: assert property ( // [R22]
                en_eff[gi] && conn |=> port_mode_ff[gi] inside
                {ST_CDP, ST_NONE})
                else $error("Connected port stayed in the cycle");
            cdp_seen_c: cover property (
                port_mode_ff[gi] == ST_CDP);
            vendor_seen_c: cover property (
                port_mode_ff[gi] == ST_PWROFF ##1
                port_mode_ff[gi] == ST_VENDOR);
            low_tier_c: cover property (
                port_mode_ff[gi] == ST_LOW);
        end
    endgenerate
endmodule

// *** design/dcmc_defines.svh ***
// Offsets, field positions, reset values and timing counts of the block.
`ifndef DCMC_DEFINES_SVH
`define DCMC_DEFINES_SVH
`define DCMC_PORT_EN_OFF   8'h06
`define DCMC_MODE_CFG_OFF  8'h0a
`define DCMC_EXT_CFG_OFF   8'h25
`define DCMC_STATUS_OFF    8'h30
`define DCMC_PORT_EN_RST   8'h00
`define DCMC_MODE_CFG_RST  8'h00
`define DCMC_EXT_CFG_RST   8'h00
`define DCMC_HICUR_BIT     4
`define DCMC_AUTODIS_BIT   1
`define DCMC_FULL_BIT      0
`define DCMC_VENDDIS_BIT   1
`define DCMC_CLK_MHZ       20
`define DCMC_PWR_OFF_US    1000
`define DCMC_PWR_OFF_CYC   (`DCMC_PWR_OFF_US * `DCMC_CLK_MHZ)
`define DCMC_STRAP_DLY     2'h2
`endif

// *** design/dcmc_pkg.sv ***
// Types shared by the charge mode controller files.
package dcmc_pkg;
    // Per-port charging mode, one-hot.
    typedef enum logic [7:0] {
        ST_NONE   = 8'h01,
        ST_CDP    = 8'h02,
        ST_DCP    = 8'h04,
        ST_HIGH   = 8'h08,
        ST_MID    = 8'h10,
        ST_LOW    = 8'h20,
        ST_VENDOR = 8'h40,
        ST_PWROFF = 8'h80
    } dcmc_state_e;
endpackage

// *** design/dcmc_sync2.sv ***
// Two-flop synchroniser for a bundle of level inputs.
`timescale 1ns/1ps
module dcmc_sync2 #(
    parameter int W = 1
) (
    // Clock and reset.
    input  wire logic         clk_sys,
    input  wire logic         sys_rst,
    // Asynchronous levels in, synchronised levels out.
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    // First stage, read only by the second stage.
    logic [W-1:0] meta_ff;

    // Both stages clear to zero under reset.
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            meta_ff  <= '0;
            sync_out <= '0;
        end else begin
            meta_ff  <= async_in;
            sync_out <= meta_ff;
        end
    end
endmodule

// *** test/dcmc_portable_dev.sv ***
// Portable device model seen by the four downstream ports.
`timescale 1ns/1ps
module dcmc_portable_dev #(
    parameter int NPORT = 4
) (
    // Clock and reset.
    input  wire logic             clk_sys,
    input  wire logic             sys_rst,
    // Port power from the hub and commands from the bench.
    input  wire logic [NPORT-1:0] power,
    input  wire logic [NPORT-1:0] want_pu,
    input  wire logic [NPORT-1:0] want_vdat,
    input  wire logic             slow,
    // Line levels seen by the hub detectors.
    output logic      [NPORT-1:0] pu_ff,
    output logic      [NPORT-1:0] vdat_ff
);
    logic [NPORT-1:0] pu_dly_ff;   // Late copy for a slow device.
    logic [NPORT-1:0] vdat_dly_ff; // Late copy for a slow device.

    // --------------------------------------------------------------
    // Line drive
    // --------------------------------------------------------------
    // An unpowered device releases D+; the hub pull-down reads 0.
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            pu_dly_ff   <= '0;
            vdat_dly_ff <= '0;
            pu_ff       <= '0;
            vdat_ff     <= '0;
        end else begin
            pu_dly_ff   <= want_pu & power;
            vdat_dly_ff <= want_vdat & power;
            pu_ff   <= power & (slow ? pu_dly_ff : want_pu);
            vdat_ff <= power & (slow ? vdat_dly_ff : want_vdat);
        end
    end
endmodule

// *** test/test_dcmc_top.sv ***
// Self-checking bench for the charge mode controller.
`timescale 1ns/1ps
`include "dcmc_defines.svh"
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_fail++; \
    $display("ERROR t=%0t got %h exp %h", $time, a, b); end end
module test_dcmc_top
    import dcmc_pkg::*;
;
    logic        clk_sys = 0, sys_rst = 1;   // Clock and reset.
    logic        wr = 0, rd = 0;             // Register strobes.
    logic [7:0]  addr = 0, wdata = 0, rdata; // Register bus.
    logic [3:0]  pins = 0, hpp = 0;          // Straps, host power.
    logic        pcm = 0, votp = 0, vbus = 0, hcfg = 0, slow = 0;
    logic [3:0]  want_pu = 0, want_vd = 0, pu, vd, pwr;
    dcmc_state_e mode [4];                   // Per-port mode.
    logic        fpm;                        // Power management flag.
    int          n_fail = 0, compares = 0;   // Result counters.

    always #25 clk_sys = ~clk_sys;

    dcmc_top #(.PWR_OFF_CYCLES(8)) dcmc_top_inst (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .reg_wr_en(wr),
        .reg_rd_en(rd), .reg_addr(addr), .reg_wdata(wdata),
        .reg_rdata_ff(rdata), .charge_enable_pins(pins),
        .pin_config_mode(pcm), .vendor_disable_otp(votp),
        .upstream_vbus_ok(vbus), .hub_configured(hcfg),
        .host_port_power(hpp), .dp_pullup_det(pu),
        .data_line_voltage_detect(vd), .port_power_en_ff(pwr),
        .port_mode_ff(mode), .full_power_managed_ff(fpm));

    dcmc_portable_dev dcmc_portable_dev_inst (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .power(pwr),
        .want_pu(want_pu), .want_vdat(want_vd), .slow(slow),
        .pu_ff(pu), .vdat_ff(vd));

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    // Reset is held for five cycles; straps stay put across it.
    task automatic do_reset();
        @(posedge clk_sys); sys_rst <= 1'b1;
        repeat (5) @(posedge clk_sys);
        sys_rst <= 1'b0;
        repeat (6) @(posedge clk_sys);
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys); wr <= 1'b1; addr <= a; wdata <= d;
        @(posedge clk_sys); wr <= 1'b0;
    endtask
    // Data lands on the edge that samples the strobe; checked at the next negedge.
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk_sys); rd <= 1'b1; addr <= a;
        @(posedge clk_sys); rd <= 1'b0;
        @(negedge clk_sys);
        `CHK(rdata, e)
    endtask
    // Waiting is bounded so a stuck machine shows as a mismatch.
    task automatic wait_mode(input int p, input dcmc_state_e m);
        for (int i = 0; i < 80 && mode[p] !== m; i++) @(negedge clk_sys);
        `CHK(mode[p], m)
    endtask
    // One detection: power must drop, then return in the next mode.
    task automatic step(input int p, input bit v, input dcmc_state_e n);
        @(posedge clk_sys);
        if (v) want_vd[p] <= 1'b1;
        else want_pu[p] <= 1'b1;
        wait_mode(p, ST_PWROFF);
        `CHK(pwr[p], 1'b0)
        @(posedge clk_sys); want_pu[p] <= 1'b0; want_vd[p] <= 1'b0;
        wait_mode(p, n);
        `CHK(pwr[p], 1'b1)
    endtask
    // Off first, so a new setting starts the cycle from its top.
    task automatic restart(input logic [7:0] cfg, input logic [7:0] ext);
        wr_reg(`DCMC_PORT_EN_OFF, 8'h00);
        wait_mode(0, ST_NONE);
        wr_reg(`DCMC_MODE_CFG_OFF, cfg);
        wr_reg(`DCMC_EXT_CFG_OFF, ext);
        wr_reg(`DCMC_PORT_EN_OFF, 8'h01);
    endtask
    task automatic conclude();
        $display("compares=%0d n_fail=%0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        #1000000;
        n_fail++;
        conclude();
    end

    initial begin
        do_reset();
        rd_chk(`DCMC_PORT_EN_OFF, `DCMC_PORT_EN_RST);
        rd_chk(`DCMC_MODE_CFG_OFF, `DCMC_MODE_CFG_RST);
        rd_chk(`DCMC_EXT_CFG_OFF, `DCMC_EXT_CFG_RST);
        rd_chk(8'h55, 8'h00);
        wr_reg(`DCMC_STATUS_OFF, 8'hff);
        rd_chk(`DCMC_STATUS_OFF, 8'h10);
        repeat (20) @(negedge clk_sys);
        `CHK(mode[0], ST_NONE)
        `CHK(fpm, 1'b0)
        $display("test registers done");
        // Default: no sweep, low current, vendor mode in the cycle.
        // Port 1 is enabled too and must not follow port 0.
        wr_reg(`DCMC_PORT_EN_OFF, 8'h03);
        rd_chk(`DCMC_PORT_EN_OFF, 8'h03);
        wait_mode(0, ST_MID);
        `CHK(pwr[0], 1'b1)
        `CHK(fpm, 1'b1)
        step(0, 0, ST_VENDOR);
        step(0, 0, ST_DCP);
        slow <= 1'b1;
        step(0, 1, ST_MID);
        `CHK(mode[1], ST_MID)
        slow <= 1'b0;
        $display("test auto cycle done");
        // Sweep with and without high current, then high current without sweep; vendor excluded.
        restart(8'h10, 8'h03);
        wait_mode(0, ST_HIGH);
        step(0, 0, ST_MID);
        step(0, 0, ST_LOW);
        step(0, 0, ST_DCP);
        step(0, 1, ST_HIGH);
        restart(8'h00, 8'h03);
        wait_mode(0, ST_MID);
        step(0, 0, ST_LOW);
        restart(8'h10, 8'h02);
        wait_mode(0, ST_HIGH);
        step(0, 0, ST_DCP);
        $display("test sweep done");
        restart(8'h02, 8'h00);
        wait_mode(0, ST_DCP);
        `CHK(pwr[0], 1'b1)
        @(posedge clk_sys);
        vbus <= 1'b1; hcfg <= 1'b1; hpp <= 4'hf;
        wait_mode(0, ST_CDP);
        `CHK(mode[1], ST_NONE)
        $display("test connected done");
        // Straps are set before reset and held well after release.
        @(posedge clk_sys);
        vbus <= 1'b0; hcfg <= 1'b0; hpp <= 4'h0;
        pcm <= 1'b1; pins <= 4'h2; votp <= 1'b0;
        do_reset();
        wait_mode(1, ST_HIGH);
        step(1, 0, ST_MID);
        step(1, 0, ST_LOW);
        step(1, 0, ST_VENDOR);
        // A register enable must not matter while pins rule.
        wr_reg(`DCMC_PORT_EN_OFF, 8'h01);
        repeat (4) @(negedge clk_sys);
        `CHK(mode[0], ST_NONE)
        $display("test pin mode done");
        conclude();
    end
endmodule
